// [smp_pkg.sv]
// constants, types and helper functions of the serial peripheral port
package smp_pkg;

  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned MIN_PHASE_CYC = 2;
  localparam int unsigned SYNC_W = 4;

  // ******************************
  // byte and bit counting
  // ******************************
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ******************************
  // half period counts of the serial clock
  // ******************************
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_ONE = 7'h01;

  // ******************************
  // master state
  // ******************************
  typedef enum logic [1:0] {
    SMP_IDLE = 2'b01,
    SMP_SHIFT = 2'b10
  } smp_state_t;

  // rate select to half period; seven distinct rates
  function automatic logic [6:0] half_period(input logic [1:0] sel, input logic dbl);
    logic [6:0] h;
    h = HALF_DIV4;
    case ({dbl, sel})
      3'b000: h = HALF_DIV4;
      3'b001: h = HALF_DIV16;
      3'b010: h = HALF_DIV64;
      3'b011: h = HALF_DIV128;
      3'b100: h = HALF_DIV2;
      3'b101: h = HALF_DIV8;
      3'b110: h = HALF_DIV32;
      3'b111: h = HALF_DIV64;
      default: h = HALF_DIV4;
    endcase
    return h;
  endfunction

  // shift one bit in, direction by bit order
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // bit presented on the line
  function automatic logic pick_out(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

endpackage

// [smp_pins_if.sv]
// pin bundle between the synchroniser and the port core
`timescale 1ns/1ps
`default_nettype none
interface smp_pins_if;
  logic [smp_pkg::SYNC_W-1:0] raw;
  logic [smp_pkg::SYNC_W-1:0] stable;
  modport sync (input raw, output stable);
  modport core (output raw, input stable);
endinterface
`default_nettype wire

// [smp_sync.sv]
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module smp_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  smp_pins_if.sync bus
);

  logic [smp_pkg::SYNC_W-1:0] s1_reg;
  logic [smp_pkg::SYNC_W-1:0] s2_reg;
  logic [smp_pkg::SYNC_W-1:0] s3_reg;
  logic [smp_pkg::SYNC_W-1:0] stable_reg;

  // ******************************
  // stages
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end
    else
    begin
      s1_reg <= bus.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ******************************
  // change counts once stages two and three agree
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stable_reg <= '1;
    else
      for (int i = 0; i < smp_pkg::SYNC_W; i++)
        if (s2_reg[i] == s3_reg[i])
          stable_reg[i] <= s3_reg[i];
  end

  assign bus.stable = stable_reg;

endmodule
`default_nettype wire

// [smp_spi_port.sv]
// byte wide serial peripheral port, master or slave
`timescale 1ns/1ps
`default_nettype none
module smp_spi_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic port_enable_bit,
  input wire logic master_select_bit,
  input wire logic transfer_irq_enable,
  input wire logic lsb_first,
  input wire logic rate_select_low,
  input wire logic rate_select_high,
  input wire logic double_speed,
  // user pin directions
  input wire logic user_mosi_dir,
  input wire logic user_sck_dir,
  input wire logic user_miso_dir,
  // data register access
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic flag_clear,
  // pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  // status
  output logic [7:0] rx_data,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic irq,
  output logic busy
);

  // ******************************
  // declarations
  // ******************************
  smp_pkg::smp_state_t state_reg;
  logic [6:0] half_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] spi_data_reg;
  logic [7:0] rx_data_reg;
  logic samp_reg;
  logic out_bit_reg;
  logic sck_out_reg;
  logic sck_prev_reg;
  logic done_flag_reg;
  logic wcol_reg;
  logic irq_reg;
  logic busy_reg;
  logic sck_oe_reg;
  logic mosi_oe_reg;
  logic miso_oe_reg;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;
  logic master_mode;
  logic slave_mode;
  logic slave_sel;
  logic slave_idle;
  logic m_tick;
  logic rise;
  logic fall;
  logic in_bit;
  logic busy_now;
  logic wr_ok;
  logic wr_col;
  logic start;
  logic done_ev;
  logic [7:0] shifted;
  logic [6:0] half;

  // ******************************
  // pin synchroniser
  // ******************************
  smp_pins_if pins ();
  assign pins.raw = {ss_n_in, miso_in, mosi_in, sck_in};
  smp_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .bus(pins.sync)
  );
  assign sck_s = pins.stable[0];
  assign mosi_s = pins.stable[1];
  assign miso_s = pins.stable[2];
  assign ss_n_s = pins.stable[3];

  // ******************************
  // decode
  // ******************************
  always_comb
  begin
    master_mode = port_enable_bit & master_select_bit;
    slave_mode = port_enable_bit & ~master_select_bit;
    slave_sel = slave_mode & ~ss_n_s;
    slave_idle = slave_mode & ss_n_s;
    half = smp_pkg::half_period({rate_select_high, rate_select_low}, double_speed);
    m_tick = (state_reg == smp_pkg::SMP_SHIFT) && (half_cnt_reg == smp_pkg::HALF_ONE);
    rise = (m_tick & ~sck_out_reg) | (slave_sel & sck_s & ~sck_prev_reg);
    fall = (m_tick & sck_out_reg) | (slave_sel & ~sck_s & sck_prev_reg);
    in_bit = master_mode ? miso_s : mosi_s;
    busy_now = (state_reg == smp_pkg::SMP_SHIFT) ||
               (slave_sel && bit_cnt_reg != smp_pkg::BIT_CNT_ZERO);
    wr_ok = data_wr & port_enable_bit & ~busy_now;
    wr_col = data_wr & port_enable_bit & busy_now;
    start = wr_ok & master_mode;
    done_ev = fall && (bit_cnt_reg == smp_pkg::BIT_CNT_FULL);
    shifted = smp_pkg::shift_in(shift_reg, samp_reg, lsb_first);
  end

  // ******************************
  // master state
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= smp_pkg::SMP_IDLE;
    else if (!master_mode)
      state_reg <= smp_pkg::SMP_IDLE;
    else
      case (state_reg)
        smp_pkg::SMP_IDLE:
          if (start)
            state_reg <= smp_pkg::SMP_SHIFT;
        smp_pkg::SMP_SHIFT:
          if (fall && bit_cnt_reg == smp_pkg::BIT_CNT_FULL)
            state_reg <= smp_pkg::SMP_IDLE;
        default:
          state_reg <= smp_pkg::SMP_IDLE;
      endcase
  end

  // ******************************
  // master clock generator
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_cnt_reg <= smp_pkg::HALF_ONE;
    else if (start || m_tick)
      half_cnt_reg <= half;
    else if (state_reg == smp_pkg::SMP_SHIFT)
      half_cnt_reg <= half_cnt_reg - smp_pkg::HALF_ONE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_out_reg <= 1'b0;
    else if (!master_mode || state_reg != smp_pkg::SMP_SHIFT)
      sck_out_reg <= 1'b0;
    else if (m_tick)
      sck_out_reg <= ~sck_out_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sck_prev_reg <= 1'b1;
    else
      sck_prev_reg <= sck_s;
  end

  // ******************************
  // bit counter
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bit_cnt_reg <= smp_pkg::BIT_CNT_ZERO;
    else if (!port_enable_bit || slave_idle || start)
      bit_cnt_reg <= smp_pkg::BIT_CNT_ZERO;
    else if (rise)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    else if (fall && bit_cnt_reg == smp_pkg::BIT_CNT_FULL)
      bit_cnt_reg <= smp_pkg::BIT_CNT_ZERO;
  end

  // ******************************
  // shift register and transmit data
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      spi_data_reg <= smp_pkg::BYTE_RESET;
    else if (wr_ok)
      spi_data_reg <= data_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg <= smp_pkg::BYTE_RESET;
      samp_reg <= 1'b0;
      out_bit_reg <= 1'b0;
    end
    else if (wr_ok)
    begin
      shift_reg <= data_wdata;
      out_bit_reg <= smp_pkg::pick_out(data_wdata, lsb_first);
    end
    else if (slave_idle)
    begin
      shift_reg <= spi_data_reg;
      out_bit_reg <= smp_pkg::pick_out(spi_data_reg, lsb_first);
    end
    else if (rise)
      samp_reg <= in_bit;
    else if (fall && bit_cnt_reg == smp_pkg::BIT_CNT_FULL)
    begin
      shift_reg <= spi_data_reg;
      out_bit_reg <= smp_pkg::pick_out(spi_data_reg, lsb_first);
    end
    else if (fall)
    begin
      shift_reg <= shifted;
      out_bit_reg <= smp_pkg::pick_out(shifted, lsb_first);
    end
  end

  // ******************************
  // receive buffer and flags
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_data_reg <= smp_pkg::BYTE_RESET;
    else if (done_ev)
      rx_data_reg <= shifted;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_flag_reg <= 1'b0;
    else if (done_ev)
      done_flag_reg <= 1'b1;
    else if (flag_clear)
      done_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wcol_reg <= 1'b0;
    else if (wr_col)
      wcol_reg <= 1'b1;
    else if (flag_clear)
      wcol_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= port_enable_bit & transfer_irq_enable & done_flag_reg;
      busy_reg <= busy_now;
    end
  end

  // ******************************
  // pin direction overrides
  // ******************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_oe_reg <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end
    else
    begin
      sck_oe_reg <= master_mode & user_sck_dir;
      mosi_oe_reg <= master_mode & user_mosi_dir;
      miso_oe_reg <= slave_sel & user_miso_dir;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign sck_out = sck_out_reg;
  assign sck_oe = sck_oe_reg;
  assign mosi_out = out_bit_reg;
  assign mosi_oe = mosi_oe_reg;
  assign miso_out = out_bit_reg;
  assign miso_oe = miso_oe_reg;
  assign rx_data = rx_data_reg;
  assign transfer_done_flag = done_flag_reg;
  assign write_collision_flag = wcol_reg;
  assign irq = irq_reg;
  assign busy = busy_reg;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_shift: assert property (start |=> state_reg == smp_pkg::SMP_SHIFT)
    else $error("master write did not start shifting");
  a_master_stop: assert property (master_mode && fall && bit_cnt_reg == smp_pkg::BIT_CNT_FULL
    |=> state_reg == smp_pkg::SMP_IDLE ##1 !sck_out_reg)
    else $error("master clock did not stop after a byte");
  a_irq_raise: assert property (port_enable_bit && transfer_irq_enable && done_ev
    |=> ##1 irq_reg)
    else $error("interrupt not raised after done");
  a_miso_tristate: assert property (slave_idle |=> !miso_oe_reg)
    else $error("miso driven while deselected");
  a_no_shift_idle: assert property (slave_idle |=> bit_cnt_reg == smp_pkg::BIT_CNT_ZERO)
    else $error("slave counted bits while deselected");
  a_done_flag: assert property (done_ev |=> done_flag_reg && rx_data_reg == $past(shifted))
    else $error("done flag or buffer wrong after byte");
  a_write_collide: assert property (wr_col |=> wcol_reg && $stable(spi_data_reg)
    && ($past(fall) || $stable(shift_reg)))
    else $error("collision write disturbed the byte");
  a_master_miso_in: assert property (master_mode |=> !miso_oe_reg)
    else $error("miso driven in master mode");
  a_bit_bound: assert property (state_reg == smp_pkg::SMP_SHIFT
    |-> bit_cnt_reg <= smp_pkg::BIT_CNT_FULL)
    else $error("bit counter ran past a byte");

endmodule
`default_nettype wire

// [smp_far_model.sv]
// far side model: slave for a master port, master for a slave port
`timescale 1ns/1ps
`default_nettype none
module smp_far_model (
  // clock
  input wire logic clk,
  // shared wires
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_i,
  // setup
  input wire logic lsb,
  input wire logic [7:0] tx,
  // drive
  output logic sck_o,
  output logic mosi_o,
  output logic miso_o,
  output logic ss_n_o,
  output logic [7:0] rx
);
  logic bit_in;
  logic frame = 1'b0;
  initial
  begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    miso_o = 1'b0;
  end
  // ******************************
  // slave side
  // ******************************
  always @(negedge ss_i)
  begin
    rx = tx;
    miso_o = lsb ? tx[0] : tx[7];
  end
  always @(posedge sck_i)
    if (!ss_i)
      bit_in = mosi_i;
  always @(negedge sck_i)
    if (!ss_i)
    begin
      rx = lsb ? {bit_in, rx[7:1]} : {rx[6:0], bit_in};
      miso_o = lsb ? rx[0] : rx[7];
    end
  // released lines change every cycle
  always @(posedge clk)
  begin
    if (ss_i)
      miso_o <= ~miso_o;
    if (!frame)
      mosi_o <= ~mosi_o;
  end
  // ******************************
  // master side
  // ******************************
  task automatic run(input logic [7:0] d, input int half, input int nb, output logic [7:0] r);
    r = 8'h00;
    frame = 1'b1;
    @(posedge clk);
    ss_n_o <= 1'b0;
    mosi_o <= lsb ? d[0] : d[7];
    for (int i = 0; i < nb; i++)
    begin
      repeat (half) @(posedge clk);
      sck_o <= 1'b1;
      r = lsb ? {miso_i, r[7:1]} : {r[6:0], miso_i};
      repeat (half) @(posedge clk);
      sck_o <= 1'b0;
      d = lsb ? d >> 1 : d << 1;
      mosi_o <= lsb ? d[0] : d[7];
    end
    repeat (half) @(posedge clk);
    ss_n_o <= 1'b1;
    frame = 1'b0;
    repeat (half) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [smp_spi_port_tb.sv]
// self-checking bench of the serial peripheral port with a far side model
`timescale 1ns/1ps
`default_nettype none
module smp_spi_port_tb;
  logic clk, rst_n, port_enable_bit, master_select_bit, transfer_irq_enable, lsb_first;
  logic rate_select_low, rate_select_high, double_speed, data_wr, flag_clear;
  logic user_mosi_dir, user_sck_dir, user_miso_dir, sck_out, sck_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, transfer_done_flag, write_collision_flag, irq, busy;
  logic far_sck, far_mosi, far_miso, far_ss_n, sel_n, sck_w, mosi_w, miso_w, ss_w;
  logic [7:0] data_wdata, rx_data, far_tx, far_rx, got, d, t;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'hdfca_fe58;
  int rises, n;
  assign sck_w = sck_oe ? sck_out : far_sck;
  assign mosi_w = mosi_oe ? mosi_out : far_mosi;
  assign miso_w = miso_oe ? miso_out : far_miso;
  assign ss_w = master_select_bit | far_ss_n; // master keeps its select input high
  smp_spi_port DUT (.clk, .rst_n, .port_enable_bit, .master_select_bit, .transfer_irq_enable,
    .lsb_first, .rate_select_low, .rate_select_high, .double_speed, .user_mosi_dir,
    .user_sck_dir, .user_miso_dir, .data_wr, .data_wdata, .flag_clear, .sck_in(sck_w),
    .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out,
    .miso_oe, .ss_n_in(ss_w), .rx_data, .transfer_done_flag, .write_collision_flag, .irq, .busy);
  smp_far_model far (.clk, .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_i(sel_n),
    .lsb(lsb_first), .tx(far_tx), .sck_o(far_sck), .mosi_o(far_mosi), .miso_o(far_miso),
    .ss_n_o(far_ss_n), .rx(far_rx));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge sck_out)
    rises++;
  // ******************************
  // helpers
  // ******************************
  function automatic logic [7:0] half_exp(input int r);
    int s;
    s = r % 4;
    return 8'h01 << ((s == 3 ? 5 : 2 * s) + (r < 4 ? 1 : 0));
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge clk);
    data_wr <= 1'b1;
    data_wdata <= v;
    @(posedge clk);
    data_wr <= 1'b0;
    #1;
  endtask
  task automatic clr;
    @(posedge clk);
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    tick(1);
    check("flags cleared", {transfer_done_flag, write_collision_flag}, 8'h00);
  endtask
  task automatic hold_sck(input logic v);
    n = 0;
    while (sck_out === v && n < 300)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic wait_done;
    n = 0;
    while (transfer_done_flag !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    check("done flag", transfer_done_flag, 8'h01);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
  // ******************************
  // tests
  // ******************************
  initial
  begin
    {rst_n, master_select_bit, transfer_irq_enable, lsb_first, far_tx} = '0;
    {rate_select_low, rate_select_high, double_speed, data_wr, flag_clear, data_wdata} = '0;
    {user_mosi_dir, user_sck_dir, user_miso_dir, port_enable_bit, sel_n} = '1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    check("idle outputs", {busy, irq, transfer_done_flag, write_collision_flag}, 8'h00);
    master_select_bit <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      {double_speed, rate_select_high, rate_select_low} <= r[2:0];
      lsb_first <= 1'($random(seed));
      transfer_irq_enable <= 1'($random(seed));
      far_tx <= 8'($random(seed));
      d = 8'($random(seed));
      tick(1);
      sel_n <= 1'b0;
      rises = 0;
      wr(d);
      hold_sck(1'b0);
      check("busy", busy, 8'h01);
      hold_sck(1'b1);
      check("sck high time", n[7:0], half_exp(r));
      wait_done;
      check("model got byte", far_rx, d);
      if (half_exp(r) >= 8)
        check("byte from model", rx_data, far_tx);
      tick(1);
      check("irq", irq, transfer_irq_enable);
      tick(2);
      check("sck rises", rises[7:0], 8'h08);
      check("idle after byte", {busy, sck_out}, 8'h00);
      check("master pins", {sck_oe, mosi_oe, miso_oe}, 8'h06);
      clr;
      sel_n <= 1'b1;
      $display("test master rate %0d done", r);
    end
    {double_speed, rate_select_high, rate_select_low} <= 3'b001;
    d = 8'ha5;
    tick(1);
    sel_n <= 1'b0;
    wr(d);
    wr(~d);
    tick(1);
    check("collision flag", write_collision_flag, 8'h01);
    wait_done;
    check("byte kept", far_rx, d);
    clr;
    sel_n <= 1'b1;
    $display("test collision done");
    master_select_bit <= 1'b0;
    lsb_first <= 1'($random(seed));
    tick(2);
    check("miso released", miso_oe, 8'h00);
    d = 8'($random(seed));
    wr(d);
    far.run(8'hff, 10, 3, got);
    tick(2);
    check("partial dropped", transfer_done_flag, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      t = 8'($random(seed));
      far.run(t, 10, 8, got);
      tick(2);
      check("slave sent", got, d);
      check("slave received", rx_data, t);
      check("slave flag", transfer_done_flag, 8'h01);
      check("miso idle", miso_oe, 8'h00);
      d = 8'($random(seed));
      wr(d);
      clr;
    end
    $display("test slave done");
    end_of_test;
  end
endmodule
`default_nettype wire
